//--- pcs_regs.svh
// register offsets, field positions, reset values and timing for pcs
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

`define PCS_OFF_FUNC_SEL    8'h00
`define PCS_OFF_CTRL        8'h04
`define PCS_OFF_STATUS      8'h08
`define PCS_OFF_LINE_EN     8'h0C

`define PCS_FSEL_LSB        4
`define PCS_FSEL_MSB        7
`define PCS_FSEL_MASK       16'hFF0F
`define PCS_FUNC_SEL_RESET  16'h0000

`define PCS_FSEL_ALL        4'h0
`define PCS_FSEL_HI12       4'h7
`define PCS_FSEL_LOW4       4'hA
`define PCS_FSEL_HI11       4'hD

// ctrl bits
`define PCS_CTRL_START      0
`define PCS_CTRL_SLEEP      1

`define PCS_SUPPLY_LOW_MS   10
`define PCS_CLK_MHZ         250
`define PCS_PULL_SETTLE     16

`endif

//--- pcs_pkg.sv
// types shared by the compensation pin sequencer
package pcs_pkg;
  typedef enum logic [2:0] {
    PCS_IDLE,
    PCS_DETECT,
    PCS_SUPPLY_LOW,
    PCS_ACTIVE,
    PCS_SLEEP,
    PCS_PARKED
  } pcs_state_e;
endpackage

//--- pcs_line_decode.sv
// function-select field to enabled line mask decoder
`timescale 1ns/1ps
`include "pcs_regs.svh"
module pcs_line_decode
  import pcs_pkg::*;
(
  // field
  input  wire logic [3:0]  func_sel,
  // enabled lines, bit n is line n
  output logic      [15:0] line_en
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic [15:0] decode_sel(input logic [3:0] s);
    logic [15:0] m;
    m = 16'h0000;
    if (s == `PCS_FSEL_ALL) begin
      m = 16'h1E0F;
    end else if (s == `PCS_FSEL_HI12) begin
      m = 16'h100F;
    end else if (s == `PCS_FSEL_LOW4) begin
      m = 16'h000F;
    end else if (s == `PCS_FSEL_HI11) begin
      m = 16'h180F;
    end
    return m;
  endfunction

  assign line_en = decode_sel(func_sel);
endmodule

//--- pcs_sync.sv
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ps
module pcs_sync (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic clk_en,
  // level
  input  wire logic din,
  output logic      dout
);
  logic meta_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else if (clk_en) begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

//--- pcs_sequencer.sv
// compensation pin sequencer top with ahb-lite register slave
//
// Implementation choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "pcs_regs.svh"
module pcs_sequencer
  import pcs_pkg::*;
#(
  parameter int CLK_MHZ     = `PCS_CLK_MHZ,
  parameter int LOW_TIME_MS = `PCS_SUPPLY_LOW_MS,
  parameter int LOW_CYCLES  = LOW_TIME_MS * 1000 * CLK_MHZ
)(
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // compensation shutdown line (line 1)
  input  wire logic        shdn_in,
  output logic             shdn_out,
  output logic             shdn_oe,
  output logic             shdn_pullup,
  // compensation supply line (line 2)
  output logic             supply_out,
  output logic             supply_oe
);
  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  // detect settle and supply low run share one counter, so the low run
  // must outlast the settle count or detect never finishes
  if (LOW_CYCLES <= `PCS_PULL_SETTLE || CLK_MHZ < 1) begin : g_bad_param
    $error("pcs_sequencer: timing parameters too small");
  end

  localparam logic [31:0] LOW_CNT = LOW_CYCLES;
  localparam logic [4:0]  SETTLE  = 5'(`PCS_PULL_SETTLE);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic hit_reg(input logic [7:0] a,
                                   input logic [7:0] off);
    return a == off;
  endfunction

  // ---------------------------------------------------------------
  // bus address phase
  // ---------------------------------------------------------------
  logic        wr_pend_q;
  logic [7:0]  addr_q;
  logic [15:0] func_sel_q;
  logic [15:0] func_sel_d;
  logic        start_q;
  logic        sleep_q;
  logic [15:0] line_en;
  logic        shdn_sync;

  wire take       = hsel & hready & htrans[1];
  wire take_wr    = take & hwrite;
  wire take_rd    = take & ~hwrite;
  wire hit_fsel   = hit_reg(addr_q, `PCS_OFF_FUNC_SEL);
  wire hit_ctrl   = hit_reg(addr_q, `PCS_OFF_CTRL);
  wire hit_stat   = hit_reg(haddr, `PCS_OFF_STATUS);
  wire hit_fsel_r = hit_reg(haddr, `PCS_OFF_FUNC_SEL);
  wire hit_ctrl_r = hit_reg(haddr, `PCS_OFF_CTRL);
  wire hit_len_r  = hit_reg(haddr, `PCS_OFF_LINE_EN);
  wire wr_fsel    = wr_pend_q & hit_fsel;
  wire wr_ctrl    = wr_pend_q & hit_ctrl;

  // only bits 7:4 move; the rest of the word is kept as stored
  assign func_sel_d = (func_sel_q & `PCS_FSEL_MASK) |
                      (hwdata[15:0] & ~`PCS_FSEL_MASK);

  // ---------------------------------------------------------------
  // line decode and pin synchroniser
  // ---------------------------------------------------------------
  pcs_line_decode u_dec (
    .func_sel (func_sel_q[`PCS_FSEL_MSB:`PCS_FSEL_LSB]),
    .line_en  (line_en)
  );

  // pin level is not timed to ref_clk
  pcs_sync u_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clk_en  (clk_en),
    .din     (shdn_in),
    .dout    (shdn_sync)
  );

  // lines 1 and 2 are usable only when the field enables them
  wire lines_ok = line_en[1] & line_en[2];

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  pcs_state_e  state_q;
  pcs_state_e  state_d;
  logic [31:0] cnt_q;
  logic        hi_pwr_q;
  logic        detected_q;

  // one counter serves the settle wait and the supply low run
  wire cnt_done    = cnt_q >= LOW_CNT - 32'h1;
  wire settle_done = cnt_q[4:0] == SETTLE;

  always_comb begin
    state_d = state_q;
    case (state_q)
      PCS_IDLE: begin
        if (start_q && lines_ok)
          state_d = PCS_DETECT;
      end
      PCS_DETECT: begin
        if (settle_done) begin
          if (shdn_sync)
            state_d = PCS_SUPPLY_LOW;
          else
            state_d = PCS_PARKED;
        end
      end
      PCS_SUPPLY_LOW: begin
        if (cnt_done)
          state_d = PCS_ACTIVE;
      end
      PCS_ACTIVE: begin
        if (sleep_q)
          state_d = PCS_SLEEP;
      end
      PCS_SLEEP: begin
        if (!sleep_q)
          state_d = PCS_ACTIVE;
      end
      PCS_PARKED: begin
        // standard variant stays parked until reset
        state_d = PCS_PARKED;
      end
      default: state_d = PCS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= PCS_IDLE;
      cnt_q   <= 32'h0;
    end else if (clk_en) begin
      state_q <= state_d;
      if (state_d != state_q)
        cnt_q <= 32'h0;
      else if (!cnt_done)
        cnt_q <= cnt_q + 32'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hi_pwr_q   <= 1'b0;
      detected_q <= 1'b0;
    end else if (clk_en && state_q == PCS_DETECT && settle_done) begin
      hi_pwr_q   <= shdn_sync;
      detected_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // pin drive, all registered
  // ---------------------------------------------------------------
  logic shdn_out_d;
  logic shdn_oe_d;
  logic pull_d;
  logic sup_out_d;
  logic sup_oe_d;

  // pins follow the next state so they move with state_q
  always_comb begin
    shdn_out_d = 1'b0;
    shdn_oe_d  = 1'b0;
    pull_d     = 1'b0;
    sup_out_d  = 1'b0;
    sup_oe_d   = 1'b0;
    case (state_d)
      PCS_DETECT: begin
        pull_d = 1'b1;
      end
      PCS_SUPPLY_LOW: begin
        pull_d   = 1'b1;
        sup_oe_d = 1'b1;
      end
      PCS_ACTIVE: begin
        shdn_oe_d = 1'b1;
        sup_oe_d  = 1'b1;
        sup_out_d = 1'b1;
      end
      PCS_SLEEP: begin
        shdn_oe_d  = 1'b1;
        shdn_out_d = 1'b1;
        sup_oe_d   = 1'b1;
        sup_out_d  = 1'b1;
      end
      PCS_PARKED: begin
        shdn_oe_d = 1'b1;
        sup_oe_d  = 1'b1;
      end
      default: begin
        shdn_oe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      shdn_out    <= 1'b0;
      shdn_oe     <= 1'b0;
      shdn_pullup <= 1'b0;
      supply_out  <= 1'b0;
      supply_oe   <= 1'b0;
    end else if (clk_en) begin
      shdn_out    <= shdn_out_d;
      shdn_oe     <= shdn_oe_d;
      shdn_pullup <= pull_d;
      supply_out  <= sup_out_d;
      supply_oe   <= sup_oe_d;
    end
  end

  // ---------------------------------------------------------------
  // registers and bus data phase
  // ---------------------------------------------------------------
  // status: bit1 detected, bit2 high power, bits 5:3 state
  wire [31:0] stat_word = {26'h0, state_q, hi_pwr_q, detected_q, 1'b0};
  wire [31:0] rd_word =
    hit_fsel_r ? {16'h0, func_sel_q} :
    hit_ctrl_r ? {30'h0, sleep_q, start_q} :
    hit_stat   ? stat_word :
    hit_len_r  ? {16'h0, line_en} : 32'h0;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
      hrdata    <= 32'h0;
    end else if (clk_en) begin
      wr_pend_q <= take_wr;
      if (take_wr)
        addr_q <= haddr;
      if (take_rd)
        hrdata <= rd_word;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      func_sel_q <= `PCS_FUNC_SEL_RESET;
      start_q    <= 1'b0;
      sleep_q    <= 1'b0;
    end else if (clk_en) begin
      if (wr_fsel)
        func_sel_q <= func_sel_d;
      if (wr_ctrl) begin
        start_q <= hwdata[`PCS_CTRL_START];
        sleep_q <= hwdata[`PCS_CTRL_SLEEP];
      end
    end
  end

  // every access completes with no wait state and an okay response
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // partner switches amplifiers once lines are set; nothing to do here
  logic unused_ok;
  assign unused_ok = ^{hsize, hwdata[31:16]};
endmodule

//--- pcs_sequencer_sva.sv
// port-level property checker for the compensation pin sequencer
`timescale 1ns/1ps
module pcs_sequencer_sva #(
  parameter int LOW_CYCLES = 50
)(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        clk_en,
  // bus
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // lines
  input wire logic        shdn_out,
  input wire logic        shdn_oe,
  input wire logic        shdn_pullup,
  input wire logic        supply_out,
  input wire logic        supply_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // --------------------------------
  // helper: length of the supply low run
  // --------------------------------
  int low_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) low_q <= 0;
    else if (supply_oe && !supply_out) low_q <= low_q + 1;
    else low_q <= 0;
  end
  wire parked = shdn_oe && !shdn_out && supply_oe && !supply_out;
  wire rd_far = hsel && hready && htrans[1] && !hwrite && clk_en
                && haddr >= 8'h10;
  sequence s_comp_enabled;
    shdn_oe && !shdn_out;
  endsequence
  sequence s_detected;
    $past(shdn_pullup) && !$past(supply_oe);
  endsequence
  // --------------------------------
  // properties
  // --------------------------------
  a_zero_wait: assert property (hreadyout)
    else $error("wait state inserted");
  a_resp_okay: assert property (!hresp)
    else $error("error response");
  a_unmapped_zero: assert property (rd_far |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_pullup_input: assert property (shdn_pullup |-> !shdn_oe)
    else $error("pull-up while driving shutdown line");
  a_low_time: assert property ($rose(supply_out) |-> low_q >= LOW_CYCLES)
    else $error("supply low interval too short");
  a_enable_pair: assert property ($rose(supply_out) |-> s_comp_enabled)
    else $error("shutdown line not driven low with supply");
  a_parked_hold: assert property (parked |=> parked)
    else $error("parked lines changed");
  a_detect_first: assert property ($rose(supply_oe) |-> s_detected)
    else $error("supply driven before detection");
  a_oe_sticky: assert property (shdn_oe |=> shdn_oe)
    else $error("shutdown line released");
  a_sleep_shdn: assert property (shdn_out |-> shdn_oe && supply_out)
    else $error("shutdown line high outside sleep");
endmodule

//--- pcs_comp_model.sv
// board compensation circuit seen from the two lines
`timescale 1ns/1ps
module pcs_comp_model (
  // variant and clock
  input  wire logic ref_clk,
  input  wire logic pro,
  // lines from the sequencer
  input  wire logic shdn_out,
  input  wire logic shdn_oe,
  input  wire logic shdn_pullup,
  input  wire logic supply_out,
  input  wire logic supply_oe,
  // line 1 level and amplifier state
  output logic      shdn_in,
  output logic      amp_on
);
  logic wobble_q = 1'b0;
  // undriven, unpulled line is not a stable value
  always @(posedge ref_clk) wobble_q <= !wobble_q;
  // standard variant grounds the line
  assign shdn_in = shdn_oe ? shdn_out : !pro ? 1'b0 :
                   shdn_pullup ? 1'b1 : wobble_q;
  assign amp_on = pro && supply_oe && supply_out && shdn_oe
                  && !shdn_out;
endmodule

//--- testbench.sv
// self-checking bench for the compensation pin sequencer
`timescale 1ns/1ps
`include "pcs_regs.svh"
module testbench;
  typedef struct { logic [31:0] wd, fs, en; } pcs_row_s;
  localparam int LOWC = 50;
  logic ref_clk, rstn, clk_en, hsel, hwrite, pro;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, rd;
  logic hreadyout, hresp, shdn_in, shdn_out, shdn_oe, shdn_pullup;
  logic supply_out, supply_oe, amp_on;
  int n_errors = 0, compares = 0, cyc = 0, low_n = 0;
  pcs_row_s rows [4] = '{'{32'h0000FF05, 32'h0, 32'h1E0F},
    '{32'h00000070, 32'h70, 32'h100F}, '{32'h0000FFAF, 32'hA0, 32'h000F},
    '{32'h000000D0, 32'hD0, 32'h180F}};
  pcs_sequencer #(.LOW_CYCLES(LOWC)) dut (.ref_clk(ref_clk), .rstn(rstn),
    .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .shdn_in(shdn_in), .shdn_out(shdn_out), .shdn_oe(shdn_oe),
    .shdn_pullup(shdn_pullup), .supply_out(supply_out),
    .supply_oe(supply_oe));
  pcs_comp_model far (.ref_clk(ref_clk), .pro(pro), .shdn_out(shdn_out),
    .shdn_oe(shdn_oe), .shdn_pullup(shdn_pullup), .supply_out(supply_out),
    .supply_oe(supply_oe), .shdn_in(shdn_in), .amp_on(amp_on));
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = !ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (supply_oe === 1'b1 && supply_out === 1'b0) low_n++;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
  endtask
  task automatic wait_state(input logic [2:0] s);
    for (int i = 0; i < 400; i++) begin
      bus(0, `PCS_OFF_STATUS, 0);
      if (rd[5:3] === s) break;
    end
  endtask
  task automatic pins(input logic [5:0] exp);
    chk({shdn_out, shdn_oe, shdn_pullup, supply_out, supply_oe, amp_on},
        exp);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    rstn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
    hwdata = 0; pro = 1; clk_en = 1;
    repeat (6) @(posedge ref_clk);
    rstn <= 1;
    pins(6'h00);
    foreach (rows[i]) begin
      bus(1, `PCS_OFF_FUNC_SEL, rows[i].wd);
      bus(0, `PCS_OFF_FUNC_SEL, 0);
      chk(rd, rows[i].fs);
      bus(0, `PCS_OFF_LINE_EN, 0);
      chk(rd, rows[i].en);
    end
    bus(0, 8'h10, 0);
    chk(rd, 0);
    bus(1, `PCS_OFF_FUNC_SEL, 32'h30);
    bus(1, `PCS_OFF_CTRL, 32'h1);
    // give a wrongly started sequencer time to leave idle
    repeat (2) @(posedge ref_clk);
    bus(0, `PCS_OFF_STATUS, 0);
    chk(rd[5:3], 0);
    bus(1, `PCS_OFF_CTRL, 32'h0);
    bus(1, `PCS_OFF_FUNC_SEL, 32'hA0);
    bus(1, `PCS_OFF_CTRL, 32'h1);
    wait_state(3'd3);
    repeat (2) @(posedge ref_clk);
    chk(rd[2:1], 2'b11);
    chk(low_n >= LOWC, 1);
    pins(6'h17);
    // frozen block ignores the sleep request
    clk_en <= 0;
    bus(1, `PCS_OFF_CTRL, 32'h3);
    repeat (3) @(posedge ref_clk);
    pins(6'h17);
    clk_en <= 1;
    bus(1, `PCS_OFF_CTRL, 32'h3);
    repeat (3) @(posedge ref_clk);
    pins(6'h36);
    bus(1, `PCS_OFF_CTRL, 32'h1);
    repeat (3) @(posedge ref_clk);
    pins(6'h17);
    @(posedge ref_clk);
    rstn <= 0;
    pro <= 0;
    repeat (6) @(posedge ref_clk);
    rstn <= 1;
    bus(1, `PCS_OFF_FUNC_SEL, 32'h70);
    bus(1, `PCS_OFF_CTRL, 32'h1);
    wait_state(3'd5);
    chk(rd[2:1], 2'b01);
    repeat (20) @(posedge ref_clk);
    pins(6'h12);
    tally_and_finish();
  end
endmodule
bind pcs_sequencer pcs_sequencer_sva #(.LOW_CYCLES(LOW_CYCLES)) chk (
  .ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .shdn_out(shdn_out), .shdn_oe(shdn_oe), .shdn_pullup(shdn_pullup),
  .supply_out(supply_out), .supply_oe(supply_oe));
